// *** src/asf_pkg.sv ***
// Constants shared by the sample buffer and interrupt logic.
// Assumes a 40 MHz ref_clk and a byte-wide register port from a serial front end.
// Operation
// - Axis sample: 10-bit two's complement, two bytes
// - Lock high byte during low read
// - Fresh flag set on update, cleared on read
// - Range codes select 2g, 4g, 8g
// - Sample-ready pulse after z store, non-latched
// - Buffer holds 32 coherent three-axis frames
// - Buffer mode stops at 32 frames
// - Stream mode: depth 31, drop oldest, overrun
// - Bypass: one frame, overrun on replace
// - Mode field: 00 bypass, 10 stream, else buffer
// - Axis select: all, x, y or z
// - Port reads low then high per axis
// - Partly read frame is discarded
// - Reads when empty return zero, no change
// - Frame counter shows current fill level
// - Config or watermark write empties the buffer
// - Watermark interrupt at programmed fill level
// - Full interrupt at mode depth, off after reset
// - Status updates on new data, disable clears
// - Non-latched status clears on condition end or read
// - Latched status cleared by status or any read
// - Two pins, mappable, polarity and drive selectable
// - Register pointer auto-increments, restarts per read
package asf_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_ID = 8'h00;
   localparam logic [7:0] ADR_DATA_FIRST = 8'h01;
   localparam logic [7:0] ADR_DATA_LAST = 8'h06;
   localparam logic [7:0] ADR_STAT_FIRST = 8'h09;
   localparam logic [7:0] ADR_STAT_FIFO = 8'h0b;
   localparam logic [7:0] ADR_FILL = 8'h0e;
   localparam logic [7:0] ADR_RANGE = 8'h0f;
   localparam logic [7:0] ADR_POWER = 8'h11;
   localparam logic [7:0] ADR_IEN = 8'h17;
   localparam logic [7:0] ADR_IMAP = 8'h1a;
   localparam logic [7:0] ADR_PINCFG = 8'h20;
   localparam logic [7:0] ADR_ICFG = 8'h21;
   localparam logic [7:0] ADR_WM = 8'h31;
   localparam logic [7:0] ADR_FCFG = 8'h3e;
   localparam logic [7:0] ADR_PORT = 8'h3f;
   // ----------------------------------------------------------------
   // Field positions and codes
   // ----------------------------------------------------------------
   localparam int B_WM = 6;
   localparam int B_FULL = 5;
   localparam int B_DRDY = 4;
   localparam int B_MAP_DRDY_A = 0;
   localparam int B_MAP_WM_A = 1;
   localparam int B_MAP_FULL_A = 2;
   localparam int B_MAP_DRDY_B = 5;
   localparam int B_MAP_WM_B = 6;
   localparam int B_MAP_FULL_B = 7;
   localparam int B_ANYCLR = 7;
   localparam int B_LOCKDIS = 6;
   localparam int B_LATCH = 0;
   localparam logic [7:0] ICFG_MASK = 8'hc1;
   localparam logic [7:0] FCFG_MASK = 8'hc3;
   localparam logic [1:0] MODE_BYPASS = 2'h0;
   localparam logic [1:0] MODE_STREAM = 2'h2;
   localparam logic [3:0] RANGE_2G = 4'h1;
   localparam logic [3:0] RANGE_4G = 4'h2;
   localparam logic [3:0] RANGE_8G = 4'h4;
   localparam logic [3:0] IDLE_FULL_RUN = 4'h0;
   localparam logic [3:0] PCFG_RST = 4'h5;
   // ----------------------------------------------------------------
   // Buffer sizes and timing
   // ----------------------------------------------------------------
   localparam logic [5:0] DEPTH_FIFO = 6'h20;
   localparam logic [5:0] DEPTH_STREAM = 6'h1f;
   localparam logic [5:0] DEPTH_BYPASS = 6'h01;
   localparam int CLK_PERIOD_NS = 25;
   localparam int DRDY_NS = 128000;
   localparam int DRDY_CYC = DRDY_NS / CLK_PERIOD_NS;
endpackage

// *** src/asf_frame_mem.sv ***
// Frame storage array for the sample buffer.
// Assumes one write per cycle and an asynchronous read of the head frame.
`timescale 1ns/1ps
module asf_frame_mem #(
   parameter int W = 30,
   parameter int D = 32,
   parameter int AW = 5
) (
   input wire logic ref_clk, // System clock.
   input wire logic we, // Write enable.
   input wire logic [AW-1:0] waddr, // Write slot.
   input wire logic [W-1:0] wdata, // Frame to store.
   input wire logic [AW-1:0] raddr, // Head slot.
   output logic [W-1:0] rdata // Head frame.
);
   logic [W-1:0] mem [D];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Frames are written whole, so all three axes stay coherent.
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   // The head frame is read without latency.
   assign rdata = mem[raddr];
endmodule // asf_frame_mem

// *** src/asf_irq_pin.sv ***
// Electrical driver of one interrupt pin.
// Assumes the outside wire resolves the output enable; the pin is released in reset and, in open drain, while its level is high.
`timescale 1ns/1ps
module asf_irq_pin (
   input wire logic ref_clk, // System clock.
   input wire logic srst, // Synchronous reset, active high.
   input wire logic active, // Interrupt asserted.
   input wire logic act_high, // Active level is high.
   input wire logic open_drain, // Open-drain drive.
   output logic pin_o, // Pin output value.
   output logic pin_oe // Pin output enable.
);
   typedef struct packed {
      logic o;
      logic oe;
   } asf_pin_t;
   asf_pin_t s_r, s_nxt;
   logic lvl;

   // ----------------------------------------------------------------
   // Drive selection
   // ----------------------------------------------------------------
   // Open drain only ever pulls low; push-pull drives both levels.
   always_comb begin
      lvl = act_high ? active : !active;
      s_nxt.o = open_drain ? 1'b0 : lvl;
      s_nxt.oe = open_drain ? !lvl : 1'b1;
   end

   // The pin is registered so the top outputs come from flops.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign pin_o = s_r.o;
   assign pin_oe = s_r.oe;

   property p_od_low;
      @(posedge ref_clk) disable iff (srst) open_drain |=> !pin_o;
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain drove high");
endmodule // asf_irq_pin

// *** src/asf_top.sv ***
// Sample registers, frame buffer and buffer interrupts of the accelerometer.
// Assumes a serial front end on ref_clk that gives address, write and
// read-byte pulses, and a converter that delivers coherent xyz samples.
`timescale 1ns/1ps
module asf_top #(
   parameter int DRDY_CYC = asf_pkg::DRDY_CYC,
   parameter logic [7:0] DEV_ID = 8'h5a // Arbitrary value.
) (
   input wire logic ref_clk, // 40 MHz clock.
   input wire logic srst, // Soft reset, active high.
   input wire logic smp_valid, // New coherent sample, pulse.
   input wire logic [9:0] smp_x, // X sample.
   input wire logic [9:0] smp_y, // Y sample.
   input wire logic [9:0] smp_z, // Z sample.
   input wire logic conv_start, // Next conversion begins, pulse.
   input wire logic reg_addr_set, // Address byte received, pulse.
   input wire logic reg_wr, // Data byte to write, pulse.
   input wire logic [7:0] reg_wdata, // Address or write data.
   input wire logic reg_rd_start, // New read phase, pulse.
   input wire logic reg_rd, // Byte read request, pulse.
   output logic [7:0] rd_data, // Read byte.
   output logic rd_valid, // Read byte valid, pulse.
   output logic [2:0] g_range_sel, // One-hot 8g, 4g, 2g.
   output logic irq_pin_a_o, // Pin a value.
   output logic irq_pin_a_oe, // Pin a enable.
   output logic irq_pin_b_o, // Pin b value.
   output logic irq_pin_b_oe // Pin b enable.
);
   typedef struct packed {
      logic [2:0][9:0] dat;
      logic [2:0] fresh;
      logic [2:0] lock;
      logic [2:0][7:0] shad;
      logic [3:0] range;
      logic [2:0] rsel;
      logic [3:0] idle;
      logic [7:0] ien;
      logic [7:0] imap;
      logic [3:0] pcfg;
      logic [7:0] icfg;
      logic [5:0] wm;
      logic [7:0] fcfg;
      logic [4:0] wp;
      logic [4:0] rp;
      logic [5:0] cnt;
      logic ovr;
      logic [2:0] bidx;
      logic st_wm;
      logic st_full;
      logic st_drdy;
      logic [15:0] tmr;
      logic [7:0] ptr;
      logic [7:0] base;
      logic [7:0] rdata;
      logic rvalid;
      logic act_a;
      logic act_b;
   } asf_state_t;

   asf_state_t s, n;
   logic mem_we;
   logic [29:0] mem_rd;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Low byte: two sample bits on top, flag in bit zero.
   function automatic logic [7:0] fmt_lo(input logic [9:0] d, input logic f);
      fmt_lo = {d[1:0], 5'h00, f};
   endfunction

   // Frame depth for the selected buffer mode.
   function automatic logic [5:0] mode_depth(input logic [1:0] m);
      if (m == asf_pkg::MODE_BYPASS) begin
         mode_depth = asf_pkg::DEPTH_BYPASS;
      end else if (m == asf_pkg::MODE_STREAM) begin
         mode_depth = asf_pkg::DEPTH_STREAM;
      end else begin
         mode_depth = asf_pkg::DEPTH_FIFO;
      end
   endfunction

   // Sticky status step: clear first, so a same-cycle set wins.
   function automatic logic stat_step(input logic cur, input logic en,
                                      input logic cond, input logic upd,
                                      input logic clr, input logic latch);
      stat_step = cur;
      if (clr || (!latch && !cond)) begin
         stat_step = 1'b0;
      end
      if (upd && cond) begin
         stat_step = 1'b1;
      end
      if (!en) begin
         stat_step = 1'b0;
      end
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   // Host access first, then the sample arrival, then buffer clearing.
   always_comb begin
      logic [1:0] ax;
      logic [1:0] fax;
      logic [9:0] fw;
      logic [5:0] dep;
      logic [2:0] last;
      logic port_rd;
      logic st_rd;
      logic clr;
      logic abandon;
      logic clr_ev;
      logic wm_c;
      logic full_c;
      logic latch;
      ax = '0;
      fax = '0;
      fw = '0;
      dep = mode_depth(s.fcfg[7:6]);
      last = (s.fcfg[1:0] == 2'h0) ? 3'h5 : 3'h1;
      port_rd = reg_rd && (s.ptr == asf_pkg::ADR_PORT);
      st_rd = reg_rd && (s.ptr >= asf_pkg::ADR_STAT_FIRST)
              && (s.ptr <= asf_pkg::ADR_STAT_FIFO);
      clr = 1'b0;
      abandon = 1'b0;
      clr_ev = 1'b0;
      wm_c = 1'b0;
      full_c = 1'b0;
      latch = s.icfg[asf_pkg::B_LATCH];
      mem_we = 1'b0;
      n = s;
      n.rvalid = 1'b0;

      // Leaving the port mid-frame drops the rest of that frame.
      abandon = (s.bidx != 3'h0)
                && (reg_addr_set || reg_rd_start || reg_wr || (reg_rd && !port_rd));
      if (abandon) begin
         n.rp = s.rp + 5'h01;
         n.cnt = s.cnt - 6'h01;
         n.bidx = 3'h0;
      end

      // The pointer restarts at the written address for each read phase.
      if (reg_addr_set) begin
         n.base = reg_wdata;
         n.ptr = reg_wdata;
      end
      if (reg_rd_start) begin
         n.ptr = s.base;
      end

      // Register writes.
      if (reg_wr) begin
         n.ptr = s.ptr + 8'h01;
         case (s.ptr)
            asf_pkg::ADR_RANGE: begin
               n.range = reg_wdata[3:0];
               n.rsel = {reg_wdata[3:0] == asf_pkg::RANGE_8G,
                         reg_wdata[3:0] == asf_pkg::RANGE_4G,
                         reg_wdata[3:0] == asf_pkg::RANGE_2G};
            end
            asf_pkg::ADR_POWER: n.idle = reg_wdata[3:0];
            asf_pkg::ADR_IEN: n.ien = reg_wdata;
            asf_pkg::ADR_IMAP: n.imap = reg_wdata;
            asf_pkg::ADR_PINCFG: n.pcfg = reg_wdata[3:0];
            asf_pkg::ADR_ICFG: n.icfg = reg_wdata & asf_pkg::ICFG_MASK;
            asf_pkg::ADR_WM: begin
               n.wm = reg_wdata[5:0];
               clr = 1'b1;
            end
            asf_pkg::ADR_FCFG: begin
               n.fcfg = reg_wdata & asf_pkg::FCFG_MASK;
               clr = 1'b1;
            end
            default: ;
         endcase
      end

      // Register reads with their side effects.
      if (reg_rd) begin
         n.rvalid = 1'b1;
         n.rdata = 8'h00;
         if (!port_rd) begin
            n.ptr = s.ptr + 8'h01;
         end
         if ((s.ptr >= asf_pkg::ADR_DATA_FIRST) && (s.ptr <= asf_pkg::ADR_DATA_LAST)) begin
            ax = 2'((s.ptr - asf_pkg::ADR_DATA_FIRST) >> 1);
            n.fresh[ax] = 1'b0;
            if (s.ptr[0]) begin
               n.rdata = fmt_lo(s.dat[ax], s.fresh[ax]);
               n.lock[ax] = !s.icfg[asf_pkg::B_LOCKDIS];
               n.shad[ax] = s.dat[ax][9:2];
            end else begin
               n.rdata = s.lock[ax] ? s.shad[ax] : s.dat[ax][9:2];
               n.lock[ax] = 1'b0;
            end
         end
         case (s.ptr)
            asf_pkg::ADR_ID: n.rdata = DEV_ID;
            asf_pkg::ADR_STAT_FIFO: begin
               n.rdata[asf_pkg::B_WM] = s.st_wm;
               n.rdata[asf_pkg::B_FULL] = s.st_full;
               n.rdata[asf_pkg::B_DRDY] = s.st_drdy;
            end
            asf_pkg::ADR_FILL: n.rdata = {s.ovr, 1'b0, s.cnt};
            asf_pkg::ADR_RANGE: n.rdata = {4'h0, s.range};
            asf_pkg::ADR_POWER: n.rdata = {4'h0, s.idle};
            asf_pkg::ADR_IEN: n.rdata = s.ien;
            asf_pkg::ADR_IMAP: n.rdata = s.imap;
            asf_pkg::ADR_PINCFG: n.rdata = {4'h0, s.pcfg};
            asf_pkg::ADR_ICFG: n.rdata = s.icfg;
            asf_pkg::ADR_WM: n.rdata = {2'h0, s.wm};
            asf_pkg::ADR_FCFG: n.rdata = s.fcfg;
            default: ;
         endcase
         // Port read: low then high byte of each selected axis.
         if (port_rd && (s.cnt != 6'h00)) begin
            fax = (s.fcfg[1:0] == 2'h0) ? s.bidx[2:1] : s.fcfg[1:0] - 2'h1;
            case (fax)
               2'h0: fw = mem_rd[29:20];
               2'h1: fw = mem_rd[19:10];
               default: fw = mem_rd[9:0];
            endcase
            n.rdata = s.bidx[0] ? fw[9:2] : fmt_lo(fw, 1'b0);
            n.bidx = s.bidx + 3'h1;
            if (s.bidx == last) begin
               n.bidx = 3'h0;
               n.rp = s.rp + 5'h01;
               n.cnt = s.cnt - 6'h01;
            end
         end // An empty port reads zero and changes nothing.
      end

      // New sample: data registers and the buffer.
      if (smp_valid) begin
         n.dat = {smp_z, smp_y, smp_x};
         n.fresh = 3'h7;
         if (n.cnt < dep) begin
            mem_we = 1'b1;
            n.wp = s.wp + 5'h01;
            n.cnt = n.cnt + 6'h01;
         end else if (s.fcfg[7:6] == asf_pkg::MODE_BYPASS
                      || s.fcfg[7:6] == asf_pkg::MODE_STREAM) begin
            mem_we = 1'b1;
            n.wp = s.wp + 5'h01;
            n.rp = n.rp + 5'h01;
            n.bidx = 3'h0;
            n.ovr = 1'b1;
         end // A full buffer in buffer mode ignores the sample.
      end

      // Buffer configuration and watermark writes empty the buffer.
      if (clr) begin
         mem_we = 1'b0;
         n.wp = 5'h00;
         n.rp = 5'h00;
         n.cnt = 6'h00;
         n.ovr = 1'b0;
         n.bidx = 3'h0;
      end

      // Buffer interrupts, judged on the updated fill level.
      wm_c = n.cnt >= n.wm;
      full_c = n.cnt == mode_depth(n.fcfg[7:6]);
      clr_ev = (latch && s.icfg[asf_pkg::B_ANYCLR]) ? reg_rd : st_rd;
      n.st_wm = stat_step(s.st_wm, n.ien[asf_pkg::B_WM], wm_c, smp_valid,
                          clr_ev, latch);
      n.st_full = stat_step(s.st_full, n.ien[asf_pkg::B_FULL], full_c, smp_valid,
                            clr_ev, latch);

      // Sample-ready pulse is never latched.
      if (s.st_drdy) begin
         if (s.idle == asf_pkg::IDLE_FULL_RUN) begin
            n.tmr = s.tmr - 16'h0001;
            n.st_drdy = s.tmr > 16'h0001;
         end else if (conv_start) begin
            n.st_drdy = 1'b0;
         end
      end
      if (smp_valid) begin
         n.st_drdy = 1'b1;
         n.tmr = 16'(DRDY_CYC);
      end
      if (!n.ien[asf_pkg::B_DRDY]) begin
         n.st_drdy = 1'b0;
      end

      // Pin routing.
      n.act_a = (n.st_wm && n.imap[asf_pkg::B_MAP_WM_A])
                || (n.st_full && n.imap[asf_pkg::B_MAP_FULL_A])
                || (n.st_drdy && n.imap[asf_pkg::B_MAP_DRDY_A]);
      n.act_b = (n.st_wm && n.imap[asf_pkg::B_MAP_WM_B])
                || (n.st_full && n.imap[asf_pkg::B_MAP_FULL_B])
                || (n.st_drdy && n.imap[asf_pkg::B_MAP_DRDY_B]);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   // Soft reset leaves both buffer interrupts disabled.
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s <= '0;
         s.pcfg <= asf_pkg::PCFG_RST;
      end else begin
         s <= n;
      end
   end

   assign rd_data = s.rdata;
   assign rd_valid = s.rvalid;
   assign g_range_sel = s.rsel;

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   asf_frame_mem #(.W(30), .D(32), .AW(5)) u_mem (
      .ref_clk(ref_clk),
      .we(mem_we),
      .waddr(s.wp),
      .wdata({smp_x, smp_y, smp_z}),
      .raddr(s.rp),
      .rdata(mem_rd)
   );

   asf_irq_pin u_pin_a (
      .ref_clk(ref_clk),
      .srst(srst),
      .active(s.act_a),
      .act_high(s.pcfg[0]),
      .open_drain(s.pcfg[1]),
      .pin_o(irq_pin_a_o),
      .pin_oe(irq_pin_a_oe)
   );

   asf_irq_pin u_pin_b (
      .ref_clk(ref_clk),
      .srst(srst),
      .active(s.act_b),
      .act_high(s.pcfg[2]),
      .open_drain(s.pcfg[3]),
      .pin_o(irq_pin_b_o),
      .pin_oe(irq_pin_b_oe)
   );

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   property p_fresh;
      smp_valid |=> s.fresh == 3'h7;
   endproperty
   a_fresh: assert property (p_fresh) else $error("fresh flags not set");

   property p_depth;
      s.cnt <= asf_pkg::DEPTH_FIFO;
   endproperty
   a_depth: assert property (p_depth) else $error("fill above 32");

   property p_ignore;
      smp_valid && !reg_rd && !reg_wr && !reg_addr_set && !reg_rd_start
      && s.fcfg[6] && s.cnt == asf_pkg::DEPTH_FIFO |=> s.cnt == 6'h20 && $stable(s.wp);
   endproperty
   a_ignore: assert property (p_ignore) else $error("full buffer took sample");

   property p_stream_ovr;
      smp_valid && !reg_wr && !reg_rd && !reg_addr_set && !reg_rd_start
      && s.fcfg[7:6] == asf_pkg::MODE_STREAM
      && s.cnt == asf_pkg::DEPTH_STREAM |=> s.ovr && s.cnt == 6'h1f;
   endproperty
   a_stream_ovr: assert property (p_stream_ovr) else $error("stream overrun missed");

   property p_bypass;
      s.fcfg[7:6] == asf_pkg::MODE_BYPASS |-> s.cnt <= 6'h01;
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypass holds two frames");

   property p_cfg_clr;
      reg_wr && (s.ptr == asf_pkg::ADR_FCFG || s.ptr == asf_pkg::ADR_WM)
      |=> s.cnt == 6'h00 && !s.ovr;
   endproperty
   a_cfg_clr: assert property (p_cfg_clr) else $error("config write kept data");

   property p_empty_rd;
      reg_rd && s.ptr == asf_pkg::ADR_PORT && s.cnt == 6'h00 && !smp_valid
      |=> rd_valid && rd_data == 8'h00 && s.cnt == 6'h00;
   endproperty
   a_empty_rd: assert property (p_empty_rd) else $error("empty port read not zero");

   property p_wm_off;
      !s.ien[asf_pkg::B_WM] |-> !s.st_wm;
   endproperty
   a_wm_off: assert property (p_wm_off) else $error("disabled watermark active");

   property p_auto_inc;
      reg_rd && s.ptr != asf_pkg::ADR_PORT |=> s.ptr == $past(s.ptr) + 8'h01;
   endproperty
   a_auto_inc: assert property (p_auto_inc) else $error("pointer not advanced");
endmodule // asf_top

// *** verification/asf_host.sv ***
// Host model that reaches the buffer registers through the byte port.
// Assumes the design answers each byte read with rd_valid one cycle later.
`timescale 1ns/1ps
module asf_host (
   input wire logic ref_clk, // System clock.
   output logic reg_addr_set, // Address pulse.
   output logic reg_wr, // Write pulse.
   output logic [7:0] reg_wdata, // Address or data.
   output logic reg_rd_start, // Read phase pulse.
   output logic reg_rd, // Byte read pulse.
   input wire logic [7:0] rd_data, // Read byte.
   input wire logic rd_valid // Read byte marker.
);
   logic [7:0] rb [0:7];
   // The port idles from time zero.
   initial begin
      {reg_addr_set, reg_wr, reg_rd_start, reg_rd, reg_wdata} = 12'h000;
   end
   // Sets the pointer, writes one byte, then scrambles the data lines.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk) {reg_addr_set, reg_wdata} <= {1'b1, a};
      @(posedge ref_clk) {reg_addr_set, reg_wr, reg_wdata} <= {2'h1, d};
      @(posedge ref_clk) {reg_wr, reg_wdata} <= {1'b0, ~d};
   endtask
   // Opens a new read phase at the address and reads n bytes, one every other cycle.
   task automatic rd(input logic [7:0] a, input int n);
      @(posedge ref_clk) {reg_addr_set, reg_wdata} <= {1'b1, a};
      @(posedge ref_clk) {reg_addr_set, reg_rd_start, reg_wdata} <= {2'h1, ~a};
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk) {reg_rd_start, reg_rd} <= 2'h1;
         @(posedge ref_clk) reg_rd <= 1'b0;
         #1 rb[i] = rd_valid ? rd_data : 8'hxx;
      end
   endtask
endmodule // asf_host

// *** verification/asf_top_tb.sv ***
// Self-checking bench of the data registers, sample buffer and buffer interrupts.
// Assumes asf_host drives the register port and the bench drives the samples.
`timescale 1ns/1ps
module asf_top_tb;
   logic ref_clk, srst, smp_valid, conv_start, reg_addr_set, reg_wr, reg_rd_start;
   logic reg_rd, rd_valid, irq_pin_a_o, irq_pin_a_oe, irq_pin_b_o, irq_pin_b_oe;
   logic [9:0] smp_x, smp_y, smp_z;
   logic [7:0] reg_wdata, rd_data;
   logic [2:0] g_range_sel;
   logic [31:0] seed;
   logic [29:0] sv [0:39];
   int np, num_errors, n_tests;
   asf_top #(.DRDY_CYC(8)) i_dut (.ref_clk(ref_clk), .srst(srst), .smp_valid(smp_valid),
      .smp_x(smp_x), .smp_y(smp_y), .smp_z(smp_z), .conv_start(conv_start),
      .reg_addr_set(reg_addr_set), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rd_start(reg_rd_start), .reg_rd(reg_rd), .rd_data(rd_data), .rd_valid(rd_valid),
      .g_range_sel(g_range_sel), .irq_pin_a_o(irq_pin_a_o), .irq_pin_a_oe(irq_pin_a_oe),
      .irq_pin_b_o(irq_pin_b_o), .irq_pin_b_oe(irq_pin_b_oe));
   asf_host i_host (.ref_clk(ref_clk), .reg_addr_set(reg_addr_set), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd_start(reg_rd_start), .reg_rd(reg_rd),
      .rd_data(rd_data), .rd_valid(rd_valid));
   // Free-running 40 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Next value of the stimulus shift register.
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Byte k of a buffered frame {x,y,z}: low byte then high byte per axis.
   function automatic logic [7:0] fbyte(input logic [29:0] f, input int k);
      logic [9:0] d;
      d = f[29 - 10 * (k / 2) -: 10];
      return k[0] ? d[9:2] : {d[1:0], 6'h00};
   endfunction
   // Compares one byte and counts it.
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Sends n random coherent samples and records them in order.
   task automatic push(input int n);
      repeat (n) begin
         seed = lfsr(seed);
         sv[np] = seed[29:0];
         np++;
         @(posedge ref_clk) {smp_valid, smp_x, smp_y, smp_z} <= {1'b1, seed[29:0]};
         @(posedge ref_clk) smp_valid <= 1'b0;
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      close_out;
   end
   // Main sequence of tests.
   initial begin
      {srst, smp_valid, conv_start, smp_x, smp_y, smp_z} = {1'b1, 32'h0};
      seed = 32'h00015b1e;
      np = 0;
      num_errors = 0;
      n_tests = 0;
      repeat (3) @(posedge ref_clk);
      srst <= 1'b0;
      // Data registers, fresh flag, unmapped read and range codes.
      push(1);
      i_host.rd(8'h01, 2);
      chk("x_lo", {sv[0][21:20], 5'h00, 1'b1}, i_host.rb[0]);
      chk("x_hi", sv[0][29:22], i_host.rb[1]);
      i_host.rd(8'h01, 1);
      chk("x_read", {sv[0][21:20], 6'h00}, i_host.rb[0]);
      i_host.rd(8'h50, 1);
      chk("unmapped", 8'h00, i_host.rb[0]);
      for (int i = 0; i < 4; i++) begin
         i_host.wr(8'h0f, 8'h01 << i);
         @(posedge ref_clk) #1;
         chk("range", (i < 3) ? 8'h01 << i : 8'h00, {5'h00, g_range_sel});
      end
      $display("test registers done");
      // Buffer mode, watermark 5 on pin b, full on pin a.
      i_host.wr(8'h3e, 8'h40);
      i_host.wr(8'h31, 8'h05);
      i_host.wr(8'h17, 8'h60);
      i_host.wr(8'h1a, 8'h44);
      np = 0;
      push(4);
      #90 chk("wm_idle", 8'h02, {6'h00, irq_pin_b_oe, irq_pin_b_o});
      push(1);
      #90 chk("wm_pin", 8'h03, {6'h00, irq_pin_b_oe, irq_pin_b_o});
      push(28);
      #90 chk("full_pin", 8'h03, {6'h00, irq_pin_a_oe, irq_pin_a_o});
      i_host.rd(8'h0e, 1);
      chk("count", 8'h20, i_host.rb[0]);
      i_host.rd(8'h0b, 1);
      chk("status", 8'h60, i_host.rb[0] & 8'h60);
      push(1);
      #90 chk("reassert", 8'h03, {6'h00, irq_pin_a_oe, irq_pin_a_o});
      i_host.wr(8'h17, 8'h00);
      #40 chk("disabled", 8'h02, {6'h00, irq_pin_a_oe, irq_pin_a_o});
      i_host.rd(8'h3f, 6);
      for (int k = 0; k < 6; k++) chk("frame", fbyte(sv[0], k), i_host.rb[k]);
      i_host.rd(8'h3f, 2);
      i_host.rd(8'h0e, 1);
      chk("abandon", 8'h1e, i_host.rb[0]);
      i_host.rd(8'h3f, 6);
      for (int k = 0; k < 6; k++) chk("next", fbyte(sv[2], k), i_host.rb[k]);
      $display("test buffer done");
      // Stream mode drops the oldest frame beyond 31.
      i_host.wr(8'h3e, 8'h80);
      i_host.rd(8'h0e, 1);
      chk("cleared", 8'h00, i_host.rb[0]);
      np = 0;
      push(32);
      i_host.rd(8'h0e, 1);
      chk("stream_cnt", 8'h9f, i_host.rb[0]);
      i_host.rd(8'h3f, 6);
      for (int k = 0; k < 6; k++) chk("oldest", fbyte(sv[1], k), i_host.rb[k]);
      $display("test stream done");
      // Bypass mode with z only, then reads past the fill level.
      i_host.wr(8'h3e, 8'h03);
      np = 0;
      push(2);
      i_host.rd(8'h3f, 4);
      for (int k = 0; k < 4; k++) begin
         chk("bypass", k < 2 ? fbyte(sv[1], k + 4) : 8'h00, i_host.rb[k]);
      end
      i_host.rd(8'h0e, 1);
      chk("replaced", 8'h80, i_host.rb[0]);
      $display("test bypass done");
      // Sample-ready on open-drain pin a: timed in full run, then ended by a conversion.
      i_host.wr(8'h17, 8'h10);
      i_host.wr(8'h1a, 8'h01);
      i_host.wr(8'h20, 8'h07);
      push(1);
      #90 chk("drdy_on", 8'h00, {6'h00, irq_pin_a_oe, irq_pin_a_o});
      #200 chk("drdy_end", 8'h02, {6'h00, irq_pin_a_oe, irq_pin_a_o});
      i_host.wr(8'h11, 8'h01);
      push(1);
      #290 chk("drdy_hold", 8'h00, {6'h00, irq_pin_a_oe, irq_pin_a_o});
      @(posedge ref_clk) conv_start <= 1'b1;
      @(posedge ref_clk) conv_start <= 1'b0;
      #40 chk("drdy_conv", 8'h02, {6'h00, irq_pin_a_oe, irq_pin_a_o});
      $display("test ready done");
      close_out;
   end
endmodule // asf_top_tb
